// [verilog/ppc_top.sv]
// Parallel I/O port controller: two port units behind one register port
// Operation
// R1: 58 lines, 13 dedicated, rest shared
// R2: Two identical units, port A and B
// R3: Change interrupt and glitch filter available
// R4: Reset: controller owns pins, drivers off
// R5: Every line bidirectional as port line
// R6: Select set/clear registers choose pin owner
// R7: Dedicated lines ignore select, read one
// R8: Controller-owned pin feeds peripheral zero
// R9: Drive enable set/clear with state readback
// R10: Drive enable acts only when controller owns
// R11: Output level set/clear with state readback
// R12: Undriven controller pin left to outside
// R13: Peripheral owns pin: its drive decides
// R14: Pin state reads actual pin level
// R15: Filter enable set/clear with state readback
// R16: Filter acts in both ownership cases
// R17: Level change flag, maskable port interrupt
// R18: 32-bit registers, undefined bits read zero
// R19: Open-drain option only pulls low
// R20: Zero bits in commands change nothing
// R21: Filter passes level stable one period
`timescale 1ns/1ps
module ppc_top
	import ppc_pkg::*;
#(
	parameter logic [REG_W-1:0] MUX_A = MUX_A_DEF,
	parameter logic [REG_W-1:0] MUX_B = MUX_B_DEF
)
(
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	// Register port
	input  wire logic [ADDR_W-1:0]    reg_addr,
	input  wire logic [REG_W-1:0]     reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output      logic [REG_W-1:0]     reg_rdata,
	// Port A pads
	input  wire logic [A_LINES-1:0]   pa_pin_i,
	output      logic [A_LINES-1:0]   pa_pin_o,
	output      logic [A_LINES-1:0]   pa_pin_oe,
	// Port A peripherals
	input  wire logic [A_LINES-1:0]   pa_per_o,
	input  wire logic [A_LINES-1:0]   pa_per_oe,
	output      logic [A_LINES-1:0]   pa_per_i,
	// Port B pads
	input  wire logic [B_LINES-1:0]   pb_pin_i,
	output      logic [B_LINES-1:0]   pb_pin_o,
	output      logic [B_LINES-1:0]   pb_pin_oe,
	// Port B peripherals
	input  wire logic [B_LINES-1:0]   pb_per_o,
	input  wire logic [B_LINES-1:0]   pb_per_oe,
	output      logic [B_LINES-1:0]   pb_per_i,
	// Port interrupts
	output      logic                 irq_a,
	output      logic                 irq_b
);

	// Mask of defined lines for a line count
	function automatic logic [REG_W-1:0] line_mask(input int n);
		line_mask = RST_ZERO;
		for (int i = 0; i < REG_W; i++)
			if (i < n)
				line_mask[i] = 1'b1;
	endfunction

	// Strobe hits a given port and offset
	function automatic logic hit(
		input logic              stb,
		input logic [ADDR_W-1:0] a,
		input int                p,
		input logic [7:0]        ofs
	);
		hit = stb && (a[ADDR_W-1:PORT_BIT+1] == '0)
			&& (a[PORT_BIT] == p[0]) && (a[7:0] == ofs);
	endfunction

	// Apply a set/clear command to the allowed bits
	function automatic logic [REG_W-1:0] set_clr(
		input logic [REG_W-1:0] cur,
		input logic [REG_W-1:0] data,
		input logic             do_set,
		input logic             do_clr,
		input logic [REG_W-1:0] allow
	);
		set_clr = cur;
		if (do_set)
			set_clr = cur | (data & allow); // R20
		else if (do_clr)
			set_clr = cur & ~(data & allow); // R20
	endfunction

	// Per-port constants
	logic [REG_W-1:0] valid   [NUM_PORTS];  // Defined lines
	logic [REG_W-1:0] muxed   [NUM_PORTS];  // Shared lines

	// Per-port pad and peripheral vectors, zero-padded
	logic [REG_W-1:0] pin_raw [NUM_PORTS];  // Pad levels
	logic [REG_W-1:0] per_o   [NUM_PORTS];  // Peripheral level
	logic [REG_W-1:0] per_oe  [NUM_PORTS];  // Peripheral enable
	logic [REG_W-1:0] per_i   [NUM_PORTS];  // To peripheral
	logic [REG_W-1:0] pin_o   [NUM_PORTS];  // Pad level out
	logic [REG_W-1:0] pin_oe  [NUM_PORTS];  // Pad enable out
	logic [REG_W-1:0] filt    [NUM_PORTS];  // Filtered levels

	// Register state
	logic [REG_W-1:0] sel_ff  [NUM_PORTS];  // Owner select
	logic [REG_W-1:0] drv_ff  [NUM_PORTS];  // Drive enable
	logic [REG_W-1:0] lvl_ff  [NUM_PORTS];  // Output level
	logic [REG_W-1:0] flt_ff  [NUM_PORTS];  // Filter enable
	logic [REG_W-1:0] od_ff   [NUM_PORTS];  // Open-drain enable
	logic [REG_W-1:0] msk_ff  [NUM_PORTS];  // Change mask
	logic [REG_W-1:0] chg_ff  [NUM_PORTS];  // Sticky change flags
	logic [REG_W-1:0] prev_ff [NUM_PORTS];  // Last filtered level
	logic [NUM_PORTS-1:0] irq_ff;           // Port interrupts
	logic             armed_ff;             // Change detect live
	logic [REG_W-1:0] rd_val  [NUM_PORTS];  // Read mux per port
	logic [REG_W-1:0] nxt_rdata;            // Next read data
	logic [REG_W-1:0] rdata_ff;             // Read data register

	// Line structure of both ports
	always_comb
	begin
		valid[0] = line_mask(A_LINES); // R1 R18
		valid[1] = line_mask(B_LINES); // R1 R18
		muxed[0] = MUX_A & valid[0];
		muxed[1] = MUX_B & valid[1];
	end

	// Pad and peripheral vectors widened to register width
	always_comb
	begin
		pin_raw[0] = {{(REG_W-A_LINES){1'b0}}, pa_pin_i};
		pin_raw[1] = {{(REG_W-B_LINES){1'b0}}, pb_pin_i};
		per_o[0]   = {{(REG_W-A_LINES){1'b0}}, pa_per_o};
		per_o[1]   = {{(REG_W-B_LINES){1'b0}}, pb_per_o};
		per_oe[0]  = {{(REG_W-A_LINES){1'b0}}, pa_per_oe};
		per_oe[1]  = {{(REG_W-B_LINES){1'b0}}, pb_per_oe};
	end

	// Narrow outputs; pad and peripheral lines are flip-flops in the pin multiplexer, interrupts and read data flip-flops here
	assign pa_pin_o  = pin_o[0][A_LINES-1:0];
	assign pa_pin_oe = pin_oe[0][A_LINES-1:0];
	assign pa_per_i  = per_i[0][A_LINES-1:0];
	assign pb_pin_o  = pin_o[1][B_LINES-1:0];
	assign pb_pin_oe = pin_oe[1][B_LINES-1:0];
	assign pb_per_i  = per_i[1][B_LINES-1:0];
	assign irq_a     = irq_ff[0];
	assign irq_b     = irq_ff[1];
	assign reg_rdata = rdata_ff;

	// Change detection held off for the first cycle after reset
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			armed_ff <= 1'b0;
		else
			armed_ff <= 1'b1;
	end

	// One identical unit per port
	for (genvar p = 0; p < NUM_PORTS; p++)
	begin : g_port // R2

		ppc_ctl_if #(.W(REG_W)) ctl ();

		// Configuration into the pin multiplexer
		assign ctl.sel  = sel_ff[p];
		assign ctl.drv  = drv_ff[p];
		assign ctl.lvl  = lvl_ff[p];
		assign ctl.od   = od_ff[p];
		assign ctl.filt = filt[p];

		// Input glitch filter
		ppc_glitch_filter #(.W(REG_W), .DEPTH(FLT_CYCLES)) u_flt
		(
			.clk_sys (clk_sys),
			.srst    (srst),
			.pin_i   (pin_raw[p]),
			.flt_en  (flt_ff[p]),
			.pin_o   (filt[p])
		); // R3

		// Ownership and drive selection
		ppc_pin_mux #(.W(REG_W)) u_mux
		(
			.clk_sys   (clk_sys),
			.srst      (srst),
			.ctl       (ctl),
			.per_o     (per_o[p]),
			.per_oe    (per_oe[p]),
			.per_i_ff  (per_i[p]),
			.pin_o_ff  (pin_o[p]),
			.pin_oe_ff (pin_oe[p])
		); // R5

		// Owner select: dedicated lines stay with the controller
		always_ff @(posedge clk_sys)
		begin
			if (srst)
				sel_ff[p] <= RST_ONES & valid[p]; // R4
			else
				sel_ff[p] <= set_clr(sel_ff[p], reg_wdata,
					hit(reg_wr, reg_addr, p, OFS_SEL_SET),
					hit(reg_wr, reg_addr, p, OFS_SEL_CLR),
					muxed[p]); // R6 R7
		end

		// Drive enable
		always_ff @(posedge clk_sys)
		begin
			if (srst)
				drv_ff[p] <= RST_ZERO; // R4
			else
				drv_ff[p] <= set_clr(drv_ff[p], reg_wdata,
					hit(reg_wr, reg_addr, p, OFS_DRV_SET),
					hit(reg_wr, reg_addr, p, OFS_DRV_CLR),
					valid[p]); // R9
		end

		// Output level
		always_ff @(posedge clk_sys)
		begin
			if (srst)
				lvl_ff[p] <= RST_ZERO;
			else
				lvl_ff[p] <= set_clr(lvl_ff[p], reg_wdata,
					hit(reg_wr, reg_addr, p, OFS_LVL_SET),
					hit(reg_wr, reg_addr, p, OFS_LVL_CLR),
					valid[p]); // R11
		end

		// Filter enable
		always_ff @(posedge clk_sys)
		begin
			if (srst)
				flt_ff[p] <= RST_ZERO;
			else
				flt_ff[p] <= set_clr(flt_ff[p], reg_wdata,
					hit(reg_wr, reg_addr, p, OFS_FLT_SET),
					hit(reg_wr, reg_addr, p, OFS_FLT_CLR),
					valid[p]); // R15
		end

		// Open-drain option
		always_ff @(posedge clk_sys)
		begin
			if (srst)
				od_ff[p] <= RST_ZERO;
			else
				od_ff[p] <= set_clr(od_ff[p], reg_wdata,
					hit(reg_wr, reg_addr, p, OFS_OD_SET),
					hit(reg_wr, reg_addr, p, OFS_OD_CLR),
					valid[p]); // R19
		end

		// Change interrupt mask
		always_ff @(posedge clk_sys)
		begin
			if (srst)
				msk_ff[p] <= RST_ZERO;
			else
				msk_ff[p] <= set_clr(msk_ff[p], reg_wdata,
					hit(reg_wr, reg_addr, p, OFS_IRQ_EN),
					hit(reg_wr, reg_addr, p, OFS_IRQ_DIS),
					valid[p]); // R17
		end

		// Previous filtered level for edge finding
		always_ff @(posedge clk_sys)
		begin
			if (srst)
				prev_ff[p] <= RST_ZERO;
			else
				prev_ff[p] <= filt[p] & valid[p];
		end

		// Sticky change flags; reading clears, a new change wins
		always_ff @(posedge clk_sys)
		begin
			if (srst)
				chg_ff[p] <= RST_ZERO;
			else if (hit(reg_rd, reg_addr, p, OFS_CHG_STATE))
				chg_ff[p] <= {REG_W{armed_ff}}
					& (filt[p] ^ prev_ff[p]) & valid[p]; // R17
			else
				chg_ff[p] <= chg_ff[p] | ({REG_W{armed_ff}}
					& (filt[p] ^ prev_ff[p]) & valid[p]); // R17
		end

		// Port interrupt from unmasked flags
		always_ff @(posedge clk_sys)
		begin
			if (srst)
				irq_ff[p] <= 1'b0;
			else
				irq_ff[p] <= |(chg_ff[p] & msk_ff[p]); // R17
		end

		// Readable registers of this port
		always_comb
		begin
			unique case (reg_addr[7:0])
				OFS_SEL_STATE: rd_val[p] = sel_ff[p]; // R6 R7
				OFS_DRV_STATE: rd_val[p] = drv_ff[p]; // R9
				OFS_FLT_STATE: rd_val[p] = flt_ff[p]; // R15
				OFS_LVL_STATE: rd_val[p] = lvl_ff[p]; // R11
				OFS_PIN_STATE: rd_val[p] = pin_raw[p]; // R14
				OFS_IRQ_MASK:  rd_val[p] = msk_ff[p];
				OFS_CHG_STATE: rd_val[p] = chg_ff[p];
				OFS_OD_STATE:  rd_val[p] = od_ff[p]; // R19
				default:       rd_val[p] = RST_ZERO;
			endcase
		end

	end

	// Read selection; unmapped addresses read zero
	always_comb
	begin
		nxt_rdata = RST_ZERO;
		if (reg_rd && (reg_addr[ADDR_W-1:PORT_BIT+1] == '0))
		begin
			if (reg_addr[PORT_BIT])
				nxt_rdata = rd_val[1] & valid[1]; // R18
			else
				nxt_rdata = rd_val[0] & valid[0]; // R18
		end
	end

	// Read data stands one cycle after the strobe only
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			rdata_ff <= RST_ZERO;
		else
			rdata_ff <= nxt_rdata;
	end

endmodule

// [verilog/ppc_pkg.sv]
// Shared constants for the parallel I/O port controller
package ppc_pkg;

	// Structure
	localparam int NUM_PORTS = 2;      // Port A and port B units
	localparam int REG_W     = 32;     // Register and line vector width
	localparam int ADDR_W    = 12;     // Byte address width
	localparam int PORT_BIT  = 8;      // Address bit picking the port
	localparam int A_LINES   = 30;     // Lines on port A
	localparam int B_LINES   = 28;     // Lines on port B (58 in total)

	// Per-port register byte offsets
	localparam logic [7:0] OFS_SEL_SET   = 8'h00;
	localparam logic [7:0] OFS_SEL_CLR   = 8'h04;
	localparam logic [7:0] OFS_SEL_STATE = 8'h08;
	localparam logic [7:0] OFS_DRV_SET   = 8'h10;
	localparam logic [7:0] OFS_DRV_CLR   = 8'h14;
	localparam logic [7:0] OFS_DRV_STATE = 8'h18;
	localparam logic [7:0] OFS_FLT_SET   = 8'h20;
	localparam logic [7:0] OFS_FLT_CLR   = 8'h24;
	localparam logic [7:0] OFS_FLT_STATE = 8'h28;
	localparam logic [7:0] OFS_LVL_SET   = 8'h30;
	localparam logic [7:0] OFS_LVL_CLR   = 8'h34;
	localparam logic [7:0] OFS_LVL_STATE = 8'h38;
	localparam logic [7:0] OFS_PIN_STATE = 8'h3c;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h40;
	localparam logic [7:0] OFS_IRQ_DIS   = 8'h44;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h48;
	localparam logic [7:0] OFS_CHG_STATE = 8'h4c;
	localparam logic [7:0] OFS_OD_SET    = 8'h50;
	localparam logic [7:0] OFS_OD_CLR    = 8'h54;
	localparam logic [7:0] OFS_OD_STATE  = 8'h58;

	// Reset values
	localparam logic [REG_W-1:0] RST_ZERO = 32'h0000_0000;
	localparam logic [REG_W-1:0] RST_ONES = 32'hffff_ffff;

	// Default peripheral-shared line masks (1 = multiplexed line)
	localparam logic [REG_W-1:0] MUX_A_DEF = 32'h3fff_ffff;
	localparam logic [REG_W-1:0] MUX_B_DEF = 32'h0000_7fff;

	// Glitch filter timing
	localparam int CLK_MHZ       = 100;
	localparam int FLT_STABLE_NS = 10;
	localparam int FLT_CYCLES    = (FLT_STABLE_NS * CLK_MHZ + 999) / 1000;

endpackage

// [verilog/ppc_ctl_if.sv]
// Configuration carrier from register file to a pin multiplexer
`timescale 1ns/1ps
interface ppc_ctl_if #(parameter int W = 32);
	logic [W-1:0] sel;   // 1 = controller owns the line
	logic [W-1:0] drv;   // Controller drive enable
	logic [W-1:0] lvl;   // Controller output level
	logic [W-1:0] od;    // Open-drain option
	logic [W-1:0] filt;  // Filtered pin level

	// Register side
	modport ctrl (output sel, output drv, output lvl, output od,
		output filt);
	// Pin side
	modport pins (input sel, input drv, input lvl, input od,
		input filt);
endinterface

// [verilog/ppc_glitch_filter.sv]
// Per-line input glitch filter with enable
`timescale 1ns/1ps
module ppc_glitch_filter
	import ppc_pkg::*;
#(
	parameter int W     = 32,
	parameter int DEPTH = FLT_CYCLES
)
(
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         srst,
	// Lines
	input  wire logic [W-1:0] pin_i,
	input  wire logic [W-1:0] flt_en,
	output      logic [W-1:0] pin_o
);

	logic [W-1:0] hist_ff [DEPTH];  // Past samples
	logic [W-1:0] held_ff;          // Accepted level
	logic [W-1:0] stable;           // Equal to all past samples

	// History shift register
	always_ff @(posedge clk_sys)
	begin
		hist_ff[0] <= srst ? RST_ZERO[W-1:0] : pin_i;
		for (int k = 1; k < DEPTH; k++)
			hist_ff[k] <= srst ? RST_ZERO[W-1:0] : hist_ff[k-1];
	end

	// Lines unchanged over the whole window
	always_comb
	begin
		stable = '1;
		for (int k = 0; k < DEPTH; k++)
			stable = stable & ~(pin_i ^ hist_ff[k]);
	end

	// Accept only a level held a full period
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			held_ff <= RST_ZERO[W-1:0];
		else
			held_ff <= (held_ff & ~stable) | (pin_i & stable); // R21
	end

	// Filter acts per line in both ownership cases
	assign pin_o = (flt_en & held_ff) | (~flt_en & pin_i); // R16

endmodule

// [verilog/ppc_pin_mux.sv]
// Ownership and drive multiplexer for one port's lines
`timescale 1ns/1ps
module ppc_pin_mux
	import ppc_pkg::*;
#(
	parameter int W = 32
)
(
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         srst,
	// Configuration
	ppc_ctl_if.pins           ctl,
	// Peripheral side
	input  wire logic [W-1:0] per_o,
	input  wire logic [W-1:0] per_oe,
	output      logic [W-1:0] per_i_ff,
	// Pad side
	output      logic [W-1:0] pin_o_ff,
	output      logic [W-1:0] pin_oe_ff
);

	logic [W-1:0] want_oe;  // Selected drive request
	logic [W-1:0] want_o;   // Selected level

	// Pick owner's level and enable
	always_comb
	begin
		want_oe = (ctl.sel & ctl.drv) | (~ctl.sel & per_oe); // R10 R12 R13
		want_o  = (ctl.sel & ctl.lvl) | (~ctl.sel & per_o); // R11 R13
	end

	// Pad drivers; open-drain lines only pull low
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			pin_o_ff  <= RST_ZERO[W-1:0];
			pin_oe_ff <= RST_ZERO[W-1:0]; // R4
		end
		else
		begin
			pin_o_ff  <= want_o & ~ctl.od; // R19
			pin_oe_ff <= want_oe & ~(ctl.od & want_o); // R19
		end
	end

	// Peripheral input held low while controller owns the line
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			per_i_ff <= RST_ZERO[W-1:0];
		else
			per_i_ff <= ctl.filt & ~ctl.sel; // R8
	end

endmodule

// [testbench/ppc_assertions.sv]
// Port-level checker for the parallel I/O port controller
`timescale 1ns/1ps
module ppc_assertions
	import ppc_pkg::*;
#(
	parameter logic [REG_W-1:0] MUX_A = MUX_A_DEF,
	parameter logic [REG_W-1:0] MUX_B = MUX_B_DEF
)
(
	// Clock and reset
	input wire logic               clk_sys,
	input wire logic               srst,
	// Register port
	input wire logic [ADDR_W-1:0]  reg_addr,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [REG_W-1:0]   reg_rdata,
	// Pads and peripherals
	input wire logic [A_LINES-1:0] pa_pin_i,
	input wire logic [A_LINES-1:0] pa_pin_oe,
	input wire logic [A_LINES-1:0] pa_per_o,
	input wire logic [A_LINES-1:0] pa_per_oe,
	input wire logic [B_LINES-1:0] pb_pin_oe,
	input wire logic               irq_a
);
	// Dedicated lines of port B
	localparam logic [REG_W-1:0] DED_B = ~MUX_B & 32'h0fff_ffff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data not zero outside read slot");
	reset_quiet_a: assert property ($fell(srst) |->
		pa_pin_oe == '0 && pb_pin_oe == '0 && !irq_a)
		else $error("drivers or interrupt active after reset");
	unmapped_zero_a: assert property ($past(reg_rd) &&
		$past(reg_addr[11:9]) != 3'h0 |-> reg_rdata == '0)
		else $error("unmapped read not zero");
	cmd_read_zero_a: assert property ($past(reg_rd) &&
		$past(reg_addr[7:0]) == OFS_DRV_SET |-> reg_rdata == '0)
		else $error("command register read not zero");
	dedicated_one_a: assert property ($past(reg_rd) &&
		$past(reg_addr) == {4'h1, OFS_SEL_STATE} |->
		(reg_rdata & DED_B) == DED_B)
		else $error("dedicated select bit not one");
	upper_zero_a: assert property ($past(reg_rd) &&
		!$past(reg_addr[8]) |-> reg_rdata[31:30] == 2'h0)
		else $error("undefined port A bits not zero");
	pin_state_a: assert property ($past(reg_rd) &&
		$past(reg_addr) == {4'h0, OFS_PIN_STATE} |->
		reg_rdata[A_LINES-1:0] == $past(pa_pin_i))
		else $error("pin state differs from pad level");
	oe_cause_a: assert property ($changed(pa_pin_oe) |->
		$past(reg_wr, 2) || $past(pa_per_oe) != $past(pa_per_oe, 2) ||
		$past(pa_per_o) != $past(pa_per_o, 2))
		else $error("drive enable moved without cause");

	// Main scenarios
	cover property ($rose(irq_a));
	cover property (pa_pin_oe != '0);
	cover property ($past(reg_rd) && reg_rdata != '0);
endmodule

bind ppc_top ppc_assertions #(.MUX_A(MUX_A), .MUX_B(MUX_B)) i_chk (
	.clk_sys, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
	.pa_pin_i, .pa_pin_oe, .pa_per_o, .pa_per_oe, .pb_pin_oe, .irq_a);

// [testbench/ppc_pad_model.sv]
// Pad wire with external driver and pull-up for one port
`timescale 1ns/1ps
module ppc_pad_model
#(
	parameter int W = 30
)
(
	// Device drive
	input  wire logic [W-1:0] pin_o,
	input  wire logic [W-1:0] pin_oe,
	// External circuit drive
	input  wire logic [W-1:0] ext_val,
	input  wire logic [W-1:0] ext_oe,
	// Resolved level
	output      logic [W-1:0] pin_lvl
);
	// Wired-AND, pull-up holds undriven lines high
	assign pin_lvl = ~((pin_oe & ~pin_o) | (ext_oe & ~ext_val));
endmodule

// [testbench/parallel_io_port_controller_tb.sv]
// Self-checking bench for the parallel I/O port controller
`timescale 1ns/1ps
module parallel_io_port_controller_tb
	import ppc_pkg::*;
;
	// Row: write, then read back
	typedef struct {
		logic [ADDR_W-1:0] wa;
		logic [REG_W-1:0]  wd;
		logic [ADDR_W-1:0] ra;
		logic [REG_W-1:0]  ex;
	} ppc_row_t;

	logic                clk_sys = 1'b0;
	logic                srst = 1'b1;
	logic [ADDR_W-1:0]   reg_addr = '0;
	logic [REG_W-1:0]    reg_wdata = '0;
	logic                reg_wr = 1'b0;
	logic                reg_rd = 1'b0;
	logic [REG_W-1:0]    reg_rdata, d;
	logic [A_LINES-1:0]  pa_pin_i, pa_pin_o, pa_pin_oe, pa_per_i;
	logic [A_LINES-1:0]  pa_per_o = '0, pa_per_oe = '0;
	logic [A_LINES-1:0]  a_ext = '0, a_ext_oe = '0;
	logic [B_LINES-1:0]  pb_pin_i, pb_pin_o, pb_pin_oe, pb_per_i;
	logic [B_LINES-1:0]  pb_per_o = '0, pb_per_oe = '0, b_ext_oe = '0;
	logic                irq_a, irq_b;
	int                  n_mismatch = 0, n_compared = 0, n_cyc = 0;

	ppc_row_t rows [16] = '{
		'{12'h004, 32'h0000_000b, 12'h008, 32'h3fff_fff4},
		'{12'h000, 32'h0000_0002, 12'h008, 32'h3fff_fff6},
		'{12'h010, 32'h0000_0007, 12'h018, 32'h0000_0007},
		'{12'h014, 32'h0000_0000, 12'h018, 32'h0000_0007},
		'{12'h030, 32'hffff_ffff, 12'h038, 32'h3fff_ffff},
		'{12'h034, 32'h3fff_fffd, 12'h038, 32'h0000_0002},
		'{12'h104, 32'hffff_ffff, 12'h108, 32'h0fff_8000},
		'{12'h100, 32'h0000_7fff, 12'h108, 32'h0fff_ffff},
		'{12'h020, 32'h0000_0008, 12'h028, 32'h0000_0008},
		'{12'h024, 32'h0000_0000, 12'h028, 32'h0000_0008},
		'{12'h040, 32'h0000_0003, 12'h048, 32'h0000_0003},
		'{12'h044, 32'hffff_ffff, 12'h048, 32'h0000_0000},
		'{12'h150, 32'h0000_0001, 12'h158, 32'h0000_0001},
		'{12'h154, 32'h0000_0000, 12'h158, 32'h0000_0001},
		'{12'h210, 32'hffff_ffff, 12'h218, 32'h0000_0000},
		'{12'h05c, 32'hffff_ffff, 12'h018, 32'h0000_0007}};

	ppc_top i_dut (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .pa_pin_i, .pa_pin_o, .pa_pin_oe, .pa_per_o,
		.pa_per_oe, .pa_per_i, .pb_pin_i, .pb_pin_o, .pb_pin_oe,
		.pb_per_o, .pb_per_oe, .pb_per_i, .irq_a, .irq_b);
	ppc_pad_model #(.W(A_LINES)) i_pad_a (.pin_o(pa_pin_o),
		.pin_oe(pa_pin_oe), .ext_val(a_ext), .ext_oe(a_ext_oe),
		.pin_lvl(pa_pin_i));
	ppc_pad_model #(.W(B_LINES)) i_pad_b (.pin_o(pb_pin_o),
		.pin_oe(pb_pin_oe), .ext_val(b_ext_oe), .ext_oe(b_ext_oe),
		.pin_lvl(pb_pin_i));

	// 100 MHz clock
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end

	// Verdict and end of run
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Compare and count
	task automatic chk(input logic [REG_W-1:0] seen,
		input logic [REG_W-1:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// One write cycle
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// One read cycle, data into d
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Let n edges pass, then settle
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Hang guard
	always @(posedge clk_sys)
	begin
		n_cyc++;
		if (n_cyc == 3000)
		begin
			n_mismatch++;
			finish_test();
		end
	end

	initial
	begin
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		rd(12'h008);
		chk(d, 32'h3fff_ffff);
		rd(12'h108);
		chk(d, 32'h0fff_ffff);
		rd(12'h018);
		chk(d, 32'h0);
		chk(pa_pin_oe, 30'h0);
		foreach (rows[i])
		begin
			wr(rows[i].wa, rows[i].wd);
			rd(rows[i].ra);
			chk(d, rows[i].ex);
		end
		// Ownership, drive and pin read-back
		@(posedge clk_sys);
		pa_per_oe <= 30'h8;
		a_ext_oe <= 30'h20;
		cyc(6);
		chk(pa_pin_oe, 30'he);
		chk(pa_pin_o & 30'he, 30'h2);
		chk(pa_per_i, 30'h1);
		rd(12'h03c);
		chk(d, 32'h3fff_ffd3);
		// Glitch filter on a peripheral line
		@(posedge clk_sys);
		pa_per_oe <= 30'h0;
		cyc(6);
		@(posedge clk_sys);
		a_ext_oe <= 30'h28;
		@(posedge clk_sys);
		a_ext_oe <= 30'h20;
		repeat (6)
		begin
			@(posedge clk_sys);
			#1 chk(pa_per_i[3], 1'b1);
		end
		@(posedge clk_sys);
		a_ext_oe <= 30'h28;
		cyc(5);
		chk(pa_per_i[3], 1'b0);
		// Change interrupt, unmasked then masked
		rd(12'h04c);
		wr(12'h040, 32'h10);
		cyc(3);
		chk(irq_a, 1'b0);
		@(posedge clk_sys);
		a_ext_oe <= 30'h38;
		cyc(5);
		chk(irq_a, 1'b1);
		rd(12'h04c);
		chk(d, 32'h10);
		cyc(3);
		chk(irq_a, 1'b0);
		wr(12'h044, 32'h10);
		@(posedge clk_sys);
		a_ext_oe <= 30'h28;
		cyc(5);
		chk(irq_a, 1'b0);
		// Open-drain on port B line 0
		wr(12'h110, 32'h1);
		wr(12'h130, 32'h1);
		cyc(2);
		chk(pb_pin_oe[0], 1'b0);
		wr(12'h134, 32'h1);
		cyc(2);
		chk({pb_pin_oe[0], pb_pin_o[0]}, 2'h2);
		wr(12'h154, 32'h1);
		wr(12'h130, 32'h1);
		cyc(2);
		chk({pb_pin_oe[0], pb_pin_o[0]}, 2'h3);
		// Command offsets read zero; port B quiet
		rd(12'h010);
		chk(d, 32'h0);
		chk(pb_per_i, 28'h0);
		chk(irq_b, 1'b0);
		// Reset in mid-run restores ownership and drivers
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		cyc(1);
		chk(pa_pin_oe, 30'h0);
		chk(pa_per_i, 30'h0);
		rd(12'h008);
		chk(d, 32'h3fff_ffff);
		rd(12'h018);
		chk(d, 32'h0);
		finish_test();
	end
endmodule
